// ==== ratr_consts.vh ====
// register addresses, field positions, reset values and timing for the tuning registers
// assumes a 200 MHz core clock
`ifndef RATR_CONSTS_VH
`define RATR_CONSTS_VH
`define RATR_ADDR_SYNTH_FILTER 8'h31
`define RATR_ADDR_STARTUP_DELAY 8'h32
`define RATR_SFT_RESET 8'h04
`define RATR_SDT_RESET 8'h49
`define RATR_SFT_SWING_BIT 7
`define RATR_SFT_WIDEN_BIT 6
`define RATR_SFT_FAST_BIT 5
`define RATR_SFT_ICP_MSB 4
`define RATR_SFT_ICP_LSB 0
`define RATR_SDT_OSC_MSB 7
`define RATR_SDT_OSC_LSB 6
`define RATR_SDT_MID_BIT 5
`define RATR_SDT_RSV_MSB 4
`define RATR_SDT_RSV_LSB 3
`define RATR_SDT_FRAC_BIT 2
`define RATR_SDT_LOCK_MSB 1
`define RATR_SDT_LOCK_LSB 0
`define RATR_CLK_MHZ 200
`define RATR_OSC_STEP_US 256
`define RATR_LOCK_STEP_US 16
`define RATR_OSC_STEP_CYC (`RATR_OSC_STEP_US * `RATR_CLK_MHZ)
`define RATR_LOCK_STEP_CYC (`RATR_LOCK_STEP_US * `RATR_CLK_MHZ)
`define RATR_ICP_STEP_UA 15
`define RATR_PD_SHORT_PS 2100
`define RATR_PD_LONG_PS 3100
`endif

// ==== ratr_wait_timer.v ====
// one-shot wait timer: counts total_cycles_in cycles after start
// assumes start_in is a single-cycle pulse from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module ratr_wait_timer #(
    parameter CNT_W = 20
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire start_in,
    input wire [CNT_W-1:0] total_cycles_in,
    output reg done_out,
    output wire busy_out
);
    reg [CNT_W-1:0] cnt_r;
    reg busy_r;
    assign busy_out = busy_r;
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= {CNT_W{1'b0}};
            busy_r <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                cnt_r <= total_cycles_in;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    busy_r <= 1'b0;
                    done_out <= 1'b1;
                    cnt_r <= {CNT_W{1'b0}};
                end else begin
                    cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // ratr_wait_timer
`default_nettype wire

// ==== ratr_tuning_regs.v ====
// two byte-wide tuning registers and the settings they drive
// assumes a byte write/read port decoded by the serial control interface
`timescale 1ns/1ps
`default_nettype none
`include "ratr_consts.vh"
// How it works
// - swing-reduce bit set by device in lower band; reduces oscillator drive.
// - widen bit lengthens phase detector reset pulse 2.1 ns to 3.1 ns.
// - fast-settle bit shortens channel filter settled delay after transient.
// - charge pump code bits 4:0, reset 00100, current is code times 15 uA.
// - oscillator startup wait 256/512/768/1024 us from bits 7:6, default 512.
// - amplitude mode only: baseband filter resets to zero or midpoint.
// - fractional-mode disable bit runs synthesizer in integer mode.
// - extra lock wait 16/32/48/64 us from bits 1:0.
module ratr_tuning_regs #(
    parameter CNT_W = 20,
    parameter SETTLE_SLOW_CYC = 400,
    parameter SETTLE_FAST_CYC = 100
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire wr_en_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    output reg [7:0] rdata_out,
    input wire lower_band_in,
    input wire osc_ready_flag_in,
    input wire pll_lock_in,
    input wire rx_transient_in,
    input wire amplitude_mode_in,
    output wire osc_swing_reduce_out,
    output wire phase_det_reset_widen_out,
    output wire [11:0] phase_det_reset_ps_out,
    output wire channel_filter_fast_settle_out,
    output wire [4:0] charge_pump_current_code_out,
    output wire [8:0] charge_pump_current_ua_out,
    output wire fractional_mode_disable_out,
    output wire amplitude_filter_midpoint_reset_out,
    output reg bb_reset_zero_out,
    output reg bb_reset_mid_out,
    output reg channel_filter_settled_out,
    output wire osc_wait_done_out,
    output wire lock_wait_done_out,
    output wire startup_busy_out
);
    reg [7:0] synth_filter_tuning_r;
    reg [7:0] startup_delay_tuning_r;
    reg lower_band_s1_r;
    reg lower_band_s2_r;
    reg osc_rdy_s1_r;
    reg osc_rdy_s2_r;
    reg osc_rdy_d_r;
    reg lock_s1_r;
    reg lock_s2_r;
    reg lock_d_r;
    reg trans_s1_r;
    reg trans_s2_r;
    reg trans_d_r;
    reg amp_s1_r;
    reg amp_s2_r;
    reg [CNT_W-1:0] settle_cnt_r;
    wire osc_rise;
    wire lock_rise;
    wire trans_rise;
    wire osc_busy;
    wire lock_busy;
    wire [1:0] osc_code;
    wire [1:0] lock_code;
    wire [CNT_W-1:0] osc_total;
    wire [CNT_W-1:0] lock_total;

    // constants held at 32 bits so that every use below cuts them to width on purpose
    localparam [31:0] PD_LONG_W = `RATR_PD_LONG_PS;
    localparam [31:0] PD_SHORT_W = `RATR_PD_SHORT_PS;
    localparam [31:0] ICP_STEP_W = `RATR_ICP_STEP_UA;
    localparam [31:0] OSC_STEP_W = `RATR_OSC_STEP_CYC;
    localparam [31:0] LOCK_STEP_W = `RATR_LOCK_STEP_CYC;
    localparam [31:0] SETTLE_SLOW_W = SETTLE_SLOW_CYC;
    localparam [31:0] SETTLE_FAST_W = SETTLE_FAST_CYC;

    // wait length: (code + 1) steps
    function [CNT_W-1:0] ratr_steps;
        input [1:0] code;
        input [CNT_W-1:0] step;
        begin
            ratr_steps = step * ({{(CNT_W-2){1'b0}}, code} + {{(CNT_W-1){1'b0}}, 1'b1});
        end
    endfunction

    // two-flop synchronisers for pin-level inputs
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lower_band_s1_r <= 1'b0;
            lower_band_s2_r <= 1'b0;
            osc_rdy_s1_r <= 1'b0;
            osc_rdy_s2_r <= 1'b0;
            osc_rdy_d_r <= 1'b0;
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
            lock_d_r <= 1'b0;
            trans_s1_r <= 1'b0;
            trans_s2_r <= 1'b0;
            trans_d_r <= 1'b0;
            amp_s1_r <= 1'b0;
            amp_s2_r <= 1'b0;
        end else begin
            lower_band_s1_r <= lower_band_in;
            lower_band_s2_r <= lower_band_s1_r;
            osc_rdy_s1_r <= osc_ready_flag_in;
            osc_rdy_s2_r <= osc_rdy_s1_r;
            osc_rdy_d_r <= osc_rdy_s2_r;
            lock_s1_r <= pll_lock_in;
            lock_s2_r <= lock_s1_r;
            lock_d_r <= lock_s2_r;
            trans_s1_r <= rx_transient_in;
            trans_s2_r <= trans_s1_r;
            trans_d_r <= trans_s2_r;
            amp_s1_r <= amplitude_mode_in;
            amp_s2_r <= amp_s1_r;
        end
    end

    assign osc_rise = osc_rdy_s2_r & ~osc_rdy_d_r;
    assign lock_rise = lock_s2_r & ~lock_d_r;
    assign trans_rise = trans_s2_r & ~trans_d_r;

    // register writes; hardware sets the swing bit in the lower band
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            synth_filter_tuning_r <= `RATR_SFT_RESET;
            startup_delay_tuning_r <= `RATR_SDT_RESET;
        end else begin
            if (wr_en_in && addr_in == `RATR_ADDR_SYNTH_FILTER) begin
                synth_filter_tuning_r <= wdata_in;
            end
            if (wr_en_in && addr_in == `RATR_ADDR_STARTUP_DELAY) begin
                startup_delay_tuning_r <= wdata_in;
            end
            if (lower_band_s2_r) begin
                synth_filter_tuning_r[`RATR_SFT_SWING_BIT] <= 1'b1;
            end
        end
    end

    always @* begin
        case (addr_in)
            `RATR_ADDR_SYNTH_FILTER: rdata_out = synth_filter_tuning_r;
            `RATR_ADDR_STARTUP_DELAY: rdata_out = startup_delay_tuning_r;
            default: rdata_out = 8'h00;
        endcase
    end

    assign osc_swing_reduce_out = synth_filter_tuning_r[`RATR_SFT_SWING_BIT];
    assign phase_det_reset_widen_out = synth_filter_tuning_r[`RATR_SFT_WIDEN_BIT];
    assign phase_det_reset_ps_out = phase_det_reset_widen_out ? PD_LONG_W[11:0]
                                                              : PD_SHORT_W[11:0];
    assign channel_filter_fast_settle_out = synth_filter_tuning_r[`RATR_SFT_FAST_BIT];
    assign charge_pump_current_code_out =
        synth_filter_tuning_r[`RATR_SFT_ICP_MSB:`RATR_SFT_ICP_LSB];
    assign charge_pump_current_ua_out =
        {4'h0, charge_pump_current_code_out} * ICP_STEP_W[8:0];
    assign fractional_mode_disable_out = startup_delay_tuning_r[`RATR_SDT_FRAC_BIT];
    assign amplitude_filter_midpoint_reset_out = startup_delay_tuning_r[`RATR_SDT_MID_BIT];

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle_cnt_r <= {CNT_W{1'b0}};
            channel_filter_settled_out <= 1'b1;
        end else if (trans_rise) begin
            settle_cnt_r <= channel_filter_fast_settle_out ? SETTLE_FAST_W[CNT_W-1:0]
                                                           : SETTLE_SLOW_W[CNT_W-1:0];
            channel_filter_settled_out <= 1'b0;
        end else if (settle_cnt_r != {CNT_W{1'b0}}) begin
            settle_cnt_r <= settle_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
            channel_filter_settled_out <= (settle_cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bb_reset_zero_out <= 1'b0;
            bb_reset_mid_out <= 1'b0;
        end else begin
            bb_reset_zero_out <= trans_rise & amp_s2_r & ~amplitude_filter_midpoint_reset_out;
            bb_reset_mid_out <= trans_rise & amp_s2_r & amplitude_filter_midpoint_reset_out;
        end
    end

    assign osc_code = startup_delay_tuning_r[`RATR_SDT_OSC_MSB:`RATR_SDT_OSC_LSB];
    assign osc_total = ratr_steps(osc_code, OSC_STEP_W[CNT_W-1:0]);
    assign lock_code = startup_delay_tuning_r[`RATR_SDT_LOCK_MSB:`RATR_SDT_LOCK_LSB];
    assign lock_total = ratr_steps(lock_code, LOCK_STEP_W[CNT_W-1:0]);

    ratr_wait_timer #(.CNT_W(CNT_W)) u_osc_wait (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(osc_rise),
        .total_cycles_in(osc_total),
        .done_out(osc_wait_done_out),
        .busy_out(osc_busy)
    );

    ratr_wait_timer #(.CNT_W(CNT_W)) u_lock_wait (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(lock_rise),
        .total_cycles_in(lock_total),
        .done_out(lock_wait_done_out),
        .busy_out(lock_busy)
    );

    assign startup_busy_out = osc_busy | lock_busy;
endmodule // ratr_tuning_regs
`default_nettype wire

// ==== ratr_host.sv ====
// host side model: byte writes and address selects on the register port
// assumes the bench clock and a one-cycle write strobe
`timescale 1ns/1ps
`default_nettype none
module ratr_host (
    input wire logic core_clk_in,
    output var logic wr_en_out,
    output var logic [7:0] addr_out,
    output var logic [7:0] wdata_out
);
    initial begin
        wr_en_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        wr_en_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge core_clk_in);
        wr_en_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    task automatic sel(input logic [7:0] a);
        @(posedge core_clk_in);
        addr_out <= a;
    endtask
endmodule // ratr_host
`default_nettype wire

// ==== ratr_chk_sva.sv ====
// checker on the tuning register ports
// assumes binding into ratr_tuning_regs
`timescale 1ns/1ps
`default_nettype none
module ratr_chk (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire wr_en_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire [7:0] rdata_out,
    input wire lower_band_in,
    input wire osc_swing_reduce_out,
    input wire phase_det_reset_widen_out,
    input wire channel_filter_fast_settle_out,
    input wire [11:0] phase_det_reset_ps_out,
    input wire [4:0] charge_pump_current_code_out,
    input wire [8:0] charge_pump_current_ua_out,
    input wire fractional_mode_disable_out,
    input wire amplitude_filter_midpoint_reset_out,
    input wire bb_reset_mid_out,
    input wire lock_wait_done_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_ua; charge_pump_current_ua_out == charge_pump_current_code_out * 9'd15; endproperty
    a_ua: assert property (p_ua) else $error("pump current wrong");
    property p_ps; phase_det_reset_ps_out == (phase_det_reset_widen_out ? 12'd3100 : 12'd2100);
    endproperty
    a_ps: assert property (p_ps) else $error("pulse width wrong");
    property p_rd; addr_in == 8'h31 |->
        rdata_out == {osc_swing_reduce_out, phase_det_reset_widen_out,
        channel_filter_fast_settle_out, charge_pump_current_code_out};
    endproperty
    a_rd: assert property (p_rd) else $error("read of first register wrong");
    property p_sw; lower_band_in [*5] |-> osc_swing_reduce_out; endproperty
    a_sw: assert property (p_sw) else $error("swing bit not set");
    property p_w2; wr_en_in && addr_in == 8'h32 |=> fractional_mode_disable_out ==
        $past(wdata_in[2]) && amplitude_filter_midpoint_reset_out == $past(wdata_in[5]);
    endproperty
    a_w2: assert property (p_w2) else $error("second register outputs wrong");
    property p_rsv; wr_en_in && addr_in == 8'h32 ##1 addr_in == 8'h32 |->
        rdata_out[4:3] == $past(wdata_in[4:3]); endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits lost");
    property p_bb; bb_reset_mid_out |-> amplitude_filter_midpoint_reset_out; endproperty
    a_bb: assert property (p_bb) else $error("midpoint reset without bit");
    property p_lk; lock_wait_done_out |=> !lock_wait_done_out; endproperty
    a_lk: assert property (p_lk) else $error("lock done not a pulse");
endmodule // ratr_chk
`default_nettype wire

// ==== radio_advanced_tuning_regs_tb.sv ====
// bench: host model writes, pins from the bench, model compares
// assumes ratr_tuning_regs with default parameters
`timescale 1ns/1ps
`default_nettype none
module radio_advanced_tuning_regs_tb;
    logic clk = 1'b0, rst_n = 1'b0, lb = 1'b0, ox = 1'b0, lk = 1'b0, tr = 1'b0, am = 1'b0;
    wire wr, sw, wi, fs, fd, mr, bz, bm, st, od, ld, bs;
    wire [7:0] ad, wd, rd;
    wire [11:0] ps;
    wire [4:0] cc;
    wire [8:0] ua;
    int err_count = 0, tests_run = 0, m31, m32, n, b, z, e;
    logic [31:0] lf = 32'h12DB160A;
    initial forever #2.5 clk = ~clk;
    ratr_host host (.core_clk_in(clk), .wr_en_out(wr), .addr_out(ad), .wdata_out(wd));
    ratr_tuning_regs uut (.core_clk_in(clk), .rst_n_in(rst_n), .wr_en_in(wr), .addr_in(ad),
        .wdata_in(wd), .rdata_out(rd), .lower_band_in(lb), .osc_ready_flag_in(ox),
        .pll_lock_in(lk), .rx_transient_in(tr), .amplitude_mode_in(am),
        .osc_swing_reduce_out(sw), .phase_det_reset_widen_out(wi), .phase_det_reset_ps_out(ps),
        .channel_filter_fast_settle_out(fs), .charge_pump_current_code_out(cc),
        .charge_pump_current_ua_out(ua), .fractional_mode_disable_out(fd),
        .amplitude_filter_midpoint_reset_out(mr), .bb_reset_zero_out(bz),
        .bb_reset_mid_out(bm), .channel_filter_settled_out(st), .osc_wait_done_out(od),
        .lock_wait_done_out(ld), .startup_busy_out(bs));
    function logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task chk(input string s, input logic [15:0] x, input logic [15:0] g);
        tests_run++;
        if (g !== x) begin
            err_count++;
            $display("BAD %s exp %h got %h", s, x, g);
        end
    endtask
    task rdc(input logic [7:0] a, input int x);
        host.sel(a);
        #1;
        chk("rdata", x[15:0], {8'h00, rd});
    endtask
    // counts edges until a done pulse of the chosen wait
    task waitp(input int k, output int c);
        c = 0;
        while (!(k ? ld : od)) begin
            @(posedge clk);
            #1;
            c++;
            if (c == 8) chk("busy", 1, bs);
            if (c > 60000) begin
                err_count++;
                test_done();
            end
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        am <= 1'b1;
        rdc(8'h31, 8'h04);
        rdc(8'h32, 8'h49);
        rdc(8'h33, 0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            lf = nx(lf);
            host.wr(8'h31, lf[7:0]);
            m31 = lf[7:0];
            host.wr(8'h32, lf[15:8]);
            m32 = lf[15:8];
            host.wr(8'h33, lf[23:16]);
            rdc(8'h31, m31);
            chk("ua", (m31 % 32) * 15, {7'd0, ua});
            chk("ps", m31[6] ? 3100 : 2100, {4'd0, ps});
            chk("bits", m31[7:5], {13'd0, sw, wi, fs});
            chk("cc", m31[4:0], {11'd0, cc});
            rdc(8'h32, m32);
            chk("frac_w", m32[2], {15'd0, fd});
            chk("mid_w", m32[5], {15'd0, mr});
        end
        $display("test writes done");
        lb <= 1'b1;
        repeat (4) @(posedge clk);
        host.wr(8'h31, 8'h04);
        rdc(8'h31, 8'h84);
        lb <= 1'b0;
        repeat (4) @(posedge clk);
        host.wr(8'h31, 8'h04);
        rdc(8'h31, 8'h04);
        $display("test band done");
        for (int k = 0; k < 3; k++) begin
            am <= (k < 2);
            host.wr(8'h32, k ? 8'h28 : 8'h08);
            host.wr(8'h31, k ? 8'h24 : 8'h04);
            tr <= 1'b1;
            n = 0;
            b = 0;
            z = 0;
            repeat (600) begin
                @(posedge clk);
                #1;
                n += !st;
                b += bm;
                z += bz;
            end
            tr <= 1'b0;
            e = k ? 100 : 400;
            chk("mid_pulses", k == 1, b[15:0]);
            chk("zero_pulses", k == 0, z[15:0]);
            chk("mid_bit", k != 0, {15'd0, mr});
            chk("settle", 1, n >= e && n <= e + 4);
            chk("frac", 0, fd);
        end
        $display("test transient done");
        ox <= 1'b1;
        waitp(0, n);
        chk("osc_wait", 1, n >= 51200 && n <= 51206);
        for (int j = 0; j < 2; j++) begin
            host.wr(8'h32, j ? 8'h0F : 8'h0C);
            lk <= 1'b1;
            waitp(1, n);
            e = (j * 3 + 1) * 3200;
            chk("lock_wait", 1, n >= e && n <= e + 6);
            lk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        $display("test waits done");
        test_done();
    end
endmodule // radio_advanced_tuning_regs_tb
bind ratr_tuning_regs ratr_chk chk (.*);
`default_nettype wire
